// ==== verilog/bws_status_bank.sv ====
// bus communication and wake source status bank with its serial command port
// assumes mode, watchdog and wake events come from logic on ref_clk; pins are asynchronous
//
// Function
// - prior state code: 10 after sleep, 01 after failure restart or fail-safe.
// - illegal stop-to-sleep and sleep without wake source report the failure code.
// - sleep attempt with uncleared wake flags records the sleep code.
// - watchdog miss count self-clears on good trigger or watchdog stop, unless stopped by failure.
// - invalid-command flag cleared only by a host serial clear.
// - configs 2/4 freeze the miss count after failure until a good trigger.
// - select bit 0: first watchdog miss forces restart only, no fail output or flag.
// - fault field bits 2:1: none, thermal, transmit dominant 20ms, bus dominant 20ms.
// - transmit-dominant timeout ends on TXD high or transmitter wake-capable/off.
// - bus-dominant timeout ends on recessive bus or transceiver wake-capable/off.
// - supply undervoltage disables transmitter, sets flag, ends when supply recovers.
// - after any fault recovery TXD must stay high for enable time before transmit.
// - undervoltage comparator enabled only while transceiver mode bit 1 is set.
// - bus timeout flag set on silence flag only with selective wake, then sticky.
// - interrupt on bus timeout in normal or stop mode when mask is 1.
// - partial-net fault on config error or counter overflow, only with selective wake.
// - clears of bus timeout ignored until next falling edge of interrupt output.
// - wake flags also set when woken out of fail-safe mode.
// - level register: dev pin 7, pull-up config 6, gpio 5:4, wake inputs 2:0.
// - gpio levels update in normal/stop for wake or switch use; always in gpio mode.
// - cyclic sensing holds sampled wake levels; gpio pins never sampled cyclically.
// - prior state at bits 7:6 of device status; 00 cleared, 11 reserved.
// - invalid serial command sets the invalid-command flag.
`timescale 1ns/10ps

module bws_status_bank
  import bws_pkg::*;
#(
  parameter int DOM_TIMEOUT = DOM_TIMEOUT_CYC
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic spi_csn,
  input wire logic spi_sck,
  input wire logic spi_sdi,
  output logic spi_sdo,
  output logic spi_sdo_oe,
  input wire logic txd_pin,
  input wire logic bus_dominant,
  input wire logic vcan_ok,
  input wire logic can_thermal,
  input wire logic dev_mode_pin,
  input wire logic pullup_cfg_pin,
  input wire logic [1:0] gpio_pin,
  input wire logic [2:0] wake_pin,
  input wire logic [2:0] can_mode,
  input wire bws_mode_s sbc_mode,
  input wire bws_wdog_s wdog_evt,
  input wire logic cfg_select,
  input wire logic cfg_2_or_4,
  input wire logic restart_fail_evt,
  input wire logic sleep_exit_evt,
  input wire logic illegal_stop_sleep,
  input wire logic sleep_no_source,
  input wire logic sleep_flags_pending,
  input wire logic bus_silence_flag,
  input wire logic timeout_irq_mask,
  input wire logic swk_cfg_error,
  input wire logic swk_count_overflow,
  input wire logic [6:0] wake_evt,
  input wire logic [1:0] gpio_is_gpio,
  input wire logic [1:0] gpio_is_wake_sw,
  input wire logic cyclic_sense,
  input wire logic sample_strobe,
  input wire logic other_irq_evt,
  output logic int_n,
  output logic tx_enable,
  output logic fail_output,
  output logic restart_req
);

  // ********************************
  // pin synchronisers
  // ********************************
  localparam int NSYNC = 13;
  // csn, txd and vcan reset to their quiet high level: no false frame edge or undervoltage after reset
  localparam logic [NSYNC-1:0] SYNC_IDLE = 13'h1280;
  logic [NSYNC-1:0] pin_m_q, pin_s_q;
  logic sck_d_q, csn_d_q;
  wire [NSYNC-1:0] pin_raw = {spi_csn, spi_sck, spi_sdi, txd_pin, bus_dominant, vcan_ok, can_thermal,
                              dev_mode_pin, pullup_cfg_pin, gpio_pin, wake_pin[2], wake_pin[1]};

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_m_q <= SYNC_IDLE;
      pin_s_q <= SYNC_IDLE;
    end else begin
      pin_m_q <= pin_raw;
      pin_s_q <= pin_m_q;
    end
  end

  logic wk0_m_q, wk0_s_q;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      wk0_m_q <= 1'b0;
      wk0_s_q <= 1'b0;
    end else begin
      wk0_m_q <= wake_pin[0];
      wk0_s_q <= wk0_m_q;
    end
  end

  wire csn_s = pin_s_q[12];
  wire sck_s = pin_s_q[11];
  wire sdi_s = pin_s_q[10];
  wire txd_s = pin_s_q[9];
  wire busdom_s = pin_s_q[8];
  wire vcan_s = pin_s_q[7];
  wire tsd_s = pin_s_q[6];
  wire devpin_s = pin_s_q[5];
  wire pullup_s = pin_s_q[4];
  wire [1:0] gpio_s = pin_s_q[3:2];
  wire [2:0] wk_s = {pin_s_q[1:0], wk0_s_q};

  // ********************************
  // serial command port
  // ********************************
  // the link clock is only sampled; 160 ns period gives 16 samples per bit
  logic [15:0] shift_q;
  logic [4:0] bit_cnt_q;
  logic [7:0] tx_q;
  logic done_q;
  bws_frame_s frame_q;
  logic [7:0] rd_data;

  wire sck_rise = sck_s & ~sck_d_q;
  wire sck_fall = ~sck_s & sck_d_q;
  wire csn_rise = csn_s & ~csn_d_q;
  wire csn_fall = ~csn_s & csn_d_q;
  wire load_tx = ~csn_s & sck_fall & (bit_cnt_q == ADDR_BITS);
  wire [6:0] rd_addr = shift_q[6:0];

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sck_d_q <= 1'b0;
      csn_d_q <= 1'b1;
      shift_q <= '0;
      bit_cnt_q <= '0;
      tx_q <= '0;
      done_q <= 1'b0;
      frame_q <= '0;
    end else begin
      sck_d_q <= sck_s;
      csn_d_q <= csn_s;
      done_q <= csn_rise;
      if (csn_fall) begin
        bit_cnt_q <= '0;
        tx_q <= '0;
      end else if (~csn_s & sck_rise) begin
        shift_q <= {shift_q[14:0], sdi_s};
        if (bit_cnt_q != 5'h1F) bit_cnt_q <= bit_cnt_q + 5'h01;
      end
      if (load_tx) tx_q <= rd_data;
      else if (~csn_s & sck_fall & (bit_cnt_q > ADDR_BITS)) tx_q <= {tx_q[6:0], 1'b0};
      if (csn_rise) frame_q <= shift_q;
    end
  end

  assign spi_sdo = tx_q[7];
  assign spi_sdo_oe = ~csn_s;

  logic [7:0] dev_status, bus_status, wake_a, wake_b, levels;
  logic frame_len_ok;
  assign frame_len_ok = 1'b1;

  wire map_ok = (frame_q.addr == ADDR_DEV_STATUS) | (frame_q.addr == ADDR_BUS_COMM) |
                (frame_q.addr == ADDR_WAKE_A) | (frame_q.addr == ADDR_WAKE_B) | (frame_q.addr == ADDR_LEVELS);
  logic [4:0] len_q;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) len_q <= '0;
    else if (csn_rise) len_q <= bit_cnt_q;
  end
  wire frame_ok = (len_q == FRAME_BITS) & map_ok;
  wire bad_cmd = done_q & ~frame_ok;
  wire clr_dev = done_q & frame_ok & frame_q.wr & (frame_q.addr == ADDR_DEV_STATUS);
  wire clr_bus = done_q & frame_ok & frame_q.wr & (frame_q.addr == ADDR_BUS_COMM);
  wire clr_wka = done_q & frame_ok & frame_q.wr & (frame_q.addr == ADDR_WAKE_A);
  wire clr_wkb = done_q & frame_ok & frame_q.wr & (frame_q.addr == ADDR_WAKE_B);

  assign rd_data = (rd_addr == ADDR_DEV_STATUS) ? dev_status :
                   (rd_addr == ADDR_BUS_COMM) ? bus_status :
                   (rd_addr == ADDR_WAKE_A) ? wake_a :
                   (rd_addr == ADDR_WAKE_B) ? wake_b :
                   (rd_addr == ADDR_LEVELS) ? levels : REG_RESET;

  // ********************************
  // device status
  // ********************************
  logic [1:0] prior_state_code_q, wdog_miss_count_q;
  logic inv_cmd_q, failure_q, frozen_q, restart_q;
  wire fail_src = restart_fail_evt | illegal_stop_sleep | sleep_no_source;
  wire sleep_src = sleep_exit_evt | sleep_flags_pending;
  wire first_miss = wdog_evt.fail & (wdog_miss_count_q == 2'h0);
  wire fail_silent = first_miss & ~cfg_select;
  wire stop_clear = wdog_evt.stopped & ~wdog_evt.stop_by_fail & ~frozen_q;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      prior_state_code_q <= PRIOR_NONE;
      wdog_miss_count_q <= 2'h0;
      inv_cmd_q <= 1'b0;
      failure_q <= 1'b0;
      frozen_q <= 1'b0;
      restart_q <= 1'b0;
    end else begin
      // set wins over host clear
      if (fail_src) prior_state_code_q <= PRIOR_FAIL;
      else if (sleep_src) prior_state_code_q <= PRIOR_SLEEP;
      else if (clr_dev) prior_state_code_q <= PRIOR_NONE;
      if (wdog_evt.fail) begin
        if (wdog_miss_count_q != WD_MISS_MAX) wdog_miss_count_q <= wdog_miss_count_q + 2'h1;
      end else if (wdog_evt.trigger_ok | stop_clear) wdog_miss_count_q <= 2'h0;
      if (wdog_evt.fail & cfg_2_or_4) frozen_q <= 1'b1;
      else if (wdog_evt.trigger_ok) frozen_q <= 1'b0;
      if (bad_cmd) inv_cmd_q <= 1'b1;
      else if (clr_dev) inv_cmd_q <= 1'b0;
      if (wdog_evt.fail & ~fail_silent) failure_q <= 1'b1;
      else if (clr_dev) failure_q <= 1'b0;
      restart_q <= wdog_evt.fail;
    end
  end

  assign dev_status = {prior_state_code_q, 2'b00, wdog_miss_count_q, inv_cmd_q, failure_q};
  assign fail_output = failure_q;
  assign restart_req = restart_q;

  // ********************************
  // transceiver faults
  // ********************************
  localparam int DW = $clog2(DOM_TIMEOUT + 1);
  logic [DW-1:0] txd_cnt_q, bus_cnt_q;
  logic txd_dom_q, bus_dom_q, uv_q, tsd_q;
  logic [1:0] fault_q;
  logic uv_flag_q;
  wire rx_on = can_mode[CAN_RX_BIT];
  wire tx_on = can_mode[CAN_RX_BIT] & can_mode[CAN_TX_BIT];
  wire uv_now = rx_on & ~vcan_s;
  wire txd_hit = tx_on & ~txd_s & (txd_cnt_q == DW'(DOM_TIMEOUT - 1));
  wire bus_hit = rx_on & busdom_s & (bus_cnt_q == DW'(DOM_TIMEOUT - 1));

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      txd_cnt_q <= '0;
      bus_cnt_q <= '0;
      txd_dom_q <= 1'b0;
      bus_dom_q <= 1'b0;
      uv_q <= 1'b0;
      tsd_q <= 1'b0;
      fault_q <= FAULT_NONE;
      uv_flag_q <= 1'b0;
    end else begin
      txd_cnt_q <= (tx_on & ~txd_s & ~txd_dom_q) ? txd_cnt_q + DW'(1) : '0;
      bus_cnt_q <= (rx_on & busdom_s & ~bus_dom_q) ? bus_cnt_q + DW'(1) : '0;
      if (txd_hit) txd_dom_q <= 1'b1;
      else if (txd_s | ~tx_on) txd_dom_q <= 1'b0;
      if (bus_hit) bus_dom_q <= 1'b1;
      else if (~busdom_s | ~rx_on) bus_dom_q <= 1'b0;
      uv_q <= uv_now;
      tsd_q <= tsd_s;
      if (bus_hit) fault_q <= FAULT_BUS_DOM;
      else if (txd_hit) fault_q <= FAULT_TXD_DOM;
      else if (tsd_s & ~tsd_q) fault_q <= FAULT_TSD;
      else if (clr_bus) fault_q <= FAULT_NONE;
      if (uv_now) uv_flag_q <= 1'b1;
      else if (clr_bus) uv_flag_q <= 1'b0;
    end
  end

  // transmitter re-enable after recovery
  localparam int TW = $clog2(TX_EN_CYC + 1);
  bws_tx_e tx_state_q, tx_state_d;
  logic [TW-1:0] settle_q;
  wire any_fault = txd_dom_q | bus_dom_q | uv_q | tsd_q;
  wire settled = settle_q == TW'(TX_EN_CYC - 1);

  always_comb begin
    tx_state_d = tx_state_q;
    case (tx_state_q)
      TX_BLOCKED: if (~any_fault & tx_on) tx_state_d = TX_SETTLE;
      TX_SETTLE: begin
        if (any_fault | ~tx_on) tx_state_d = TX_BLOCKED;
        else if (settled & txd_s) tx_state_d = TX_ACTIVE;
      end
      TX_ACTIVE: if (any_fault | ~tx_on) tx_state_d = TX_BLOCKED;
      default: tx_state_d = TX_BLOCKED;
    endcase
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_state_q <= TX_BLOCKED;
      settle_q <= '0;
    end else begin
      tx_state_q <= tx_state_d;
      // a low TXD restarts the enable time
      if (tx_state_q != TX_SETTLE | ~txd_s) settle_q <= '0;
      else if (~settled) settle_q <= settle_q + TW'(1);
    end
  end
  assign tx_enable = tx_state_q == TX_ACTIVE;

  // ********************************
  // selective wake flags, interrupt
  // ********************************
  logic sil_d_q, bus_timeout_flag_q, pnf_q, lock_q, int_n_q, int_d_q;
  logic [$clog2(INT_PULSE_CYC + 1)-1:0] pulse_q;
  wire swk_on = can_mode[CAN_SWK_BIT];
  wire to_set = swk_on & bus_silence_flag & ~sil_d_q;
  wire irq_req = (to_set & timeout_irq_mask & (sbc_mode.normal | sbc_mode.stop)) | other_irq_evt;
  wire int_fall = int_d_q & ~int_n_q;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sil_d_q <= 1'b0;
      bus_timeout_flag_q <= 1'b0;
      pnf_q <= 1'b0;
      lock_q <= 1'b0;
      int_n_q <= 1'b1;
      int_d_q <= 1'b1;
      pulse_q <= '0;
    end else begin
      sil_d_q <= bus_silence_flag;
      if (to_set) bus_timeout_flag_q <= 1'b1;
      else if (clr_bus & ~lock_q) bus_timeout_flag_q <= 1'b0;
      // clear is blocked until the host has seen the interrupt start
      if (to_set) lock_q <= 1'b1;
      else if (int_fall) lock_q <= 1'b0;
      if (swk_on & (swk_cfg_error | swk_count_overflow)) pnf_q <= 1'b1;
      else if (clr_bus) pnf_q <= 1'b0;
      int_d_q <= int_n_q;
      if (irq_req & int_n_q) begin
        int_n_q <= 1'b0;
        pulse_q <= '0;
      end else if (~int_n_q) begin
        if (pulse_q == $bits(pulse_q)'(INT_PULSE_CYC - 1)) int_n_q <= 1'b1;
        else pulse_q <= pulse_q + $bits(pulse_q)'(1);
      end
    end
  end
  assign int_n = int_n_q;
  assign bus_status = {3'b000, bus_timeout_flag_q, pnf_q, fault_q, uv_flag_q};

  // ********************************
  // wake sources, levels
  // ********************************
  // wake_evt: [6] bus, [5] timer, [4:2] inputs 3..1, [1:0] gpio 2..1, any mode incl. fail-safe
  logic [6:0] wake_q;
  logic [2:0] wk_lvl_q;
  logic [1:0] gpio_lvl_q;
  wire [6:0] wake_clr = {{5{clr_wka}}, {2{clr_wkb}}};

  genvar gi;
  generate
    for (gi = 0; gi < 7; gi++) begin : g_wake
      always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) wake_q[gi] <= 1'b0;
        else if (wake_evt[gi]) wake_q[gi] <= 1'b1;
        else if (wake_clr[gi]) wake_q[gi] <= 1'b0;
      end
    end
  endgenerate

  wire gpio_upd_mode = sbc_mode.normal | sbc_mode.stop;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      wk_lvl_q <= '0;
      gpio_lvl_q <= '0;
    end else begin
      if (~cyclic_sense | sample_strobe) wk_lvl_q <= wk_s;
      for (int i = 0; i < 2; i++) begin
        if (gpio_is_gpio[i] | (gpio_upd_mode & gpio_is_wake_sw[i])) gpio_lvl_q[i] <= gpio_s[i];
      end
    end
  end

  assign wake_a = {2'b00, wake_q[6:5], 1'b0, wake_q[4:2]};
  assign wake_b = {2'b00, wake_q[1:0], 4'h0};
  assign levels = {devpin_s, pullup_s, gpio_lvl_q, 1'b0, wk_lvl_q};

endmodule // bws_status_bank

// ==== inc/bws_pkg.sv ====
// constants, codes and carrier types for the bus and wake status bank
// assumes a single 100 MHz logic clock shared by every user of this package
package bws_pkg;

  // ********************************
  // timing
  // ********************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int DOM_TIMEOUT_MS = 20;
  localparam int DOM_TIMEOUT_CYC = DOM_TIMEOUT_MS * 1000000 / CLK_PERIOD_NS;
  localparam int TX_EN_TIME_NS = 1000;
  localparam int TX_EN_CYC = (TX_EN_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int INT_PULSE_NS = 1000;
  localparam int INT_PULSE_CYC = INT_PULSE_NS / CLK_PERIOD_NS;

  // ********************************
  // register map, serial frame
  // ********************************
  localparam logic [6:0] ADDR_DEV_STATUS = 7'h43;
  localparam logic [6:0] ADDR_BUS_COMM = 7'h44;
  localparam logic [6:0] ADDR_WAKE_A = 7'h46;
  localparam logic [6:0] ADDR_WAKE_B = 7'h47;
  localparam logic [6:0] ADDR_LEVELS = 7'h48;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [4:0] FRAME_BITS = 5'h10;
  localparam logic [4:0] ADDR_BITS = 5'h08;

  // ********************************
  // field codes
  // ********************************
  localparam logic [1:0] PRIOR_NONE = 2'h0;
  localparam logic [1:0] PRIOR_FAIL = 2'h1;
  localparam logic [1:0] PRIOR_SLEEP = 2'h2;
  localparam logic [1:0] FAULT_NONE = 2'h0;
  localparam logic [1:0] FAULT_TSD = 2'h1;
  localparam logic [1:0] FAULT_TXD_DOM = 2'h2;
  localparam logic [1:0] FAULT_BUS_DOM = 2'h3;
  localparam logic [1:0] WD_MISS_MAX = 2'h2;
  // transceiver mode: bit1 receiver on, bit0 transmitter on, bit2 selective wake
  localparam int CAN_RX_BIT = 1;
  localparam int CAN_TX_BIT = 0;
  localparam int CAN_SWK_BIT = 2;

  typedef struct packed {
    logic wr;
    logic [6:0] addr;
    logic [7:0] data;
  } bws_frame_s;

  typedef struct packed {
    logic normal;
    logic stop;
  } bws_mode_s;

  typedef struct packed {
    logic trigger_ok;
    logic fail;
    logic stopped;
    logic stop_by_fail;
  } bws_wdog_s;

  typedef enum logic [2:0] {
    TX_BLOCKED = 3'b001,
    TX_SETTLE = 3'b010,
    TX_ACTIVE = 3'b100
  } bws_tx_e;

endpackage

// ==== verification/bws_status_bank_asserts.sv ====
// checker for the bus and wake status bank, bound to its top module
// assumes a single ref_clk domain and the package timing constants
`timescale 1ns/10ps

module bws_status_bank_asserts
  import bws_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic spi_csn,
  input wire logic txd_pin,
  input wire logic vcan_ok,
  input wire logic [2:0] can_mode,
  input wire bws_mode_s sbc_mode,
  input wire bws_wdog_s wdog_evt,
  input wire logic cfg_select,
  input wire logic bus_silence_flag,
  input wire logic timeout_irq_mask,
  input wire logic other_irq_evt,
  input wire logic int_n,
  input wire logic tx_enable,
  input wire logic fail_output,
  input wire logic restart_req
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  // ********************
  // helper logic
  // ********************
  // raw pin count runs ahead of the synced one, so it bounds it from above
  logic [7:0] txd_hi_q;
  logic [7:0] txd_hi_d;
  logic irq_arm;
  assign txd_hi_d = !txd_pin ? 8'h00 : (txd_hi_q == 8'hFF ? txd_hi_q : txd_hi_q + 8'h01);
  assign irq_arm = can_mode[CAN_SWK_BIT] && timeout_irq_mask && (sbc_mode.normal || sbc_mode.stop);
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      txd_hi_q <= 8'h00;
    end else begin
      txd_hi_q <= txd_hi_d;
    end
  end

  // ********************
  // properties
  // ********************
  sequence s_int_start;
    ##[1:3] !int_n;
  endsequence
  sequence s_quiet;
    !other_irq_evt [*3];
  endsequence
  property p_restart_follows;
    wdog_evt.fail |=> restart_req;
  endproperty
  property p_restart_cause;
    restart_req |-> $past(wdog_evt.fail);
  endproperty
  property p_fail_out;
    wdog_evt.fail && cfg_select |-> ##[1:2] fail_output;
  endproperty
  property p_fail_hold;
    $fell(fail_output) |-> spi_csn;
  endproperty
  property p_uv_block;
    (!vcan_ok && can_mode[CAN_RX_BIT]) [*5] |-> !tx_enable;
  endproperty
  property p_tx_settle;
    $rose(tx_enable) |-> txd_hi_q >= TX_EN_CYC - 2;
  endproperty
  property p_int_timeout;
    $rose(bus_silence_flag) && irq_arm && int_n |-> s_int_start;
  endproperty
  property p_no_int;
    ($rose(bus_silence_flag) && !irq_arm && int_n && !other_irq_evt) ##1 s_quiet |=> int_n;
  endproperty
  a_restart_follows: assert property (p_restart_follows) else $error("no restart after miss");
  a_restart_cause: assert property (p_restart_cause) else $error("restart without miss");
  a_fail_out: assert property (p_fail_out) else $error("fail output not raised");
  a_fail_hold: assert property (p_fail_hold) else $error("fail output dropped in frame");
  a_uv_block: assert property (p_uv_block) else $error("transmitter on in undervoltage");
  a_tx_settle: assert property (p_tx_settle) else $error("transmitter on too early");
  a_int_timeout: assert property (p_int_timeout) else $error("timeout interrupt missing");
  a_no_int: assert property (p_no_int) else $error("unexpected timeout interrupt");
endmodule // bws_status_bank_asserts

bind bws_status_bank bws_status_bank_asserts u_asserts (.ref_clk(ref_clk), .reset_n(reset_n),
  .spi_csn(spi_csn), .txd_pin(txd_pin), .vcan_ok(vcan_ok), .can_mode(can_mode), .sbc_mode(sbc_mode),
  .wdog_evt(wdog_evt), .cfg_select(cfg_select), .bus_silence_flag(bus_silence_flag),
  .timeout_irq_mask(timeout_irq_mask), .other_irq_evt(other_irq_evt), .int_n(int_n),
  .tx_enable(tx_enable), .fail_output(fail_output), .restart_req(restart_req));

// ==== verification/bws_host_model.sv ====
// host side of the serial command port, most significant bit first
// assumes ref_clk paces it; sck idles low and stands still between frames
`timescale 1ns/10ps

module bws_host_model (
  input wire logic ref_clk,
  output logic spi_csn,
  output logic spi_sck,
  output logic spi_sdi,
  input wire logic spi_sdo,
  input wire logic spi_sdo_oe
);
  // ********************
  // frame task
  // ********************
  initial begin
    spi_csn = 1'b1;
    spi_sck = 1'b0;
    spi_sdi = 1'b0;
  end
  // short frames are how a refused command is provoked
  task automatic xfer(input int n, input logic [15:0] w, output logic [7:0] rd);
    rd = 8'h00;
    @(posedge ref_clk);
    spi_csn <= 1'b0;
    repeat (3) @(posedge ref_clk);
    for (int i = 15; i > 15 - n; i--) begin
      spi_sdi <= w[i];
      repeat (8) @(posedge ref_clk);
      spi_sck <= 1'b1;
      repeat (8) @(posedge ref_clk);
      rd = {rd[6:0], spi_sdo_oe ? spi_sdo : 1'bx};
      spi_sck <= 1'b0;
    end
    repeat (8) @(posedge ref_clk);
    spi_csn <= 1'b1;
    // released data line must not keep its last value
    spi_sdi <= ~spi_sdi;
    repeat (8) @(posedge ref_clk);
  endtask
endmodule // bws_host_model

// ==== verification/bus_wake_status_bank_tb_top.sv ====
// self-checking bench for the bus and wake status bank
// assumes the host model owns the serial pins; all other inputs are driven here
`timescale 1ns/10ps

module bus_wake_status_bank_tb_top
  import bws_pkg::*;
;
  int fail_count = 0;
  int check_count = 0;
  logic ref_clk;
  logic reset_n = 1'b0;
  logic spi_csn, spi_sck, spi_sdi, spi_sdo, spi_sdo_oe, int_n, tx_enable, fail_output, restart_req;
  logic [3:0] flt = 4'h0;
  logic [7:0] lvl = 8'hA5;
  logic [2:0] cm = 3'h3;
  bws_mode_s md = 2'h2;
  bws_wdog_s wd = 4'h0;
  logic [4:0] ev = 5'h00;
  logic [6:0] we = 7'h00;
  logic [1:0] gg = 2'h3;
  logic cs = 1'b1, c24 = 1'b0, sil = 1'b0, mask = 1'b1, se = 1'b0, cy = 1'b0, ss = 1'b0, oi = 1'b0;
  logic [7:0] d;
  logic [6:0] ra [4] = '{ADDR_DEV_STATUS, ADDR_BUS_COMM, ADDR_WAKE_A, ADDR_WAKE_B};
  logic [7:0] pexp [5] = '{8'h40, 8'h80, 8'h40, 8'h40, 8'h80};
  logic [7:0] fexp [4] = '{8'h01, 8'h04, 8'h06, 8'h02};

  // ********************
  // design and host
  // ********************
  // short dominant timeout keeps the fault runs brief
  bws_status_bank #(.DOM_TIMEOUT(50)) dut (.ref_clk(ref_clk), .reset_n(reset_n), .spi_csn(spi_csn),
    .spi_sck(spi_sck), .spi_sdi(spi_sdi), .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe), .txd_pin(!flt[1]),
    .bus_dominant(flt[2]), .vcan_ok(!flt[0]), .can_thermal(flt[3]), .dev_mode_pin(lvl[7]),
    .pullup_cfg_pin(lvl[6]), .gpio_pin(lvl[5:4]), .wake_pin(lvl[2:0]), .can_mode(cm), .sbc_mode(md),
    .wdog_evt(wd), .cfg_select(cs), .cfg_2_or_4(c24), .restart_fail_evt(ev[0]), .sleep_exit_evt(ev[1]),
    .illegal_stop_sleep(ev[2]), .sleep_no_source(ev[3]), .sleep_flags_pending(ev[4]),
    .bus_silence_flag(sil), .timeout_irq_mask(mask), .swk_cfg_error(se), .swk_count_overflow(1'b0),
    .wake_evt(we), .gpio_is_gpio(gg), .gpio_is_wake_sw(2'h0), .cyclic_sense(cy), .sample_strobe(ss),
    .other_irq_evt(oi), .int_n(int_n), .tx_enable(tx_enable), .fail_output(fail_output),
    .restart_req(restart_req));
  bws_host_model host (.ref_clk(ref_clk), .spi_csn(spi_csn), .spi_sck(spi_sck), .spi_sdi(spi_sdi),
    .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe));

  // ********************
  // tasks
  // ********************
  task automatic conclude();
    if (fail_count == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic rchk(input logic [6:0] a, input logic [7:0] exp);
    host.xfer(16, {1'b0, a, 8'h00}, d);
    check($sformatf("reg %h", a), d, exp);
  endtask
  task automatic clr(input logic [6:0] a);
    host.xfer(16, {1'b1, a, 8'h00}, d);
  endtask
  task automatic pwd(input logic [3:0] v);
    wd <= v;
    tick(1);
    wd <= 4'h0;
  endtask
  // bounded wait; a missing interrupt ends the run
  task automatic wait_int();
    for (int i = 0; i < 8 && int_n !== 1'b0; i++) tick(1);
    check("int_n", {7'h00, int_n}, 8'h00);
    if (int_n !== 1'b0) conclude();
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  initial begin
    tick(100000);
    fail_count++;
    conclude();
  end

  // ********************
  // scenarios
  // ********************
  initial begin
    tick(3);
    reset_n <= 1'b1;
    tick(120);
    check("tx_enable", {7'h00, tx_enable}, 8'h01);
    foreach (ra[i]) rchk(ra[i], 8'h00);
    we <= 7'h7F;
    tick(1);
    we <= 7'h00;
    rchk(ADDR_WAKE_A, 8'h37);
    rchk(ADDR_WAKE_A, 8'h37);
    rchk(ADDR_WAKE_B, 8'h30);
    clr(ADDR_WAKE_A);
    clr(ADDR_WAKE_B);
    rchk(ADDR_WAKE_A, 8'h00);
    rchk(ADDR_WAKE_B, 8'h00);
    clr(ADDR_LEVELS);
    rchk(ADDR_LEVELS, 8'hA5);
    cy <= 1'b1;
    ss <= 1'b1;
    tick(1);
    ss <= 1'b0;
    lvl <= 8'h92;
    tick(5);
    rchk(ADDR_LEVELS, 8'h95);
    ss <= 1'b1;
    tick(1);
    ss <= 1'b0;
    rchk(ADDR_LEVELS, 8'h92);
    cy <= 1'b0;
    host.xfer(12, 16'h0000, d);
    rchk(ADDR_DEV_STATUS, 8'h02);
    pwd(4'h2);
    rchk(ADDR_DEV_STATUS, 8'h02);
    clr(ADDR_DEV_STATUS);
    host.xfer(16, {1'b0, 7'h45, 8'h00}, d);
    rchk(ADDR_DEV_STATUS, 8'h02);
    clr(ADDR_DEV_STATUS);
    for (int i = 0; i < 5; i++) begin
      ev <= 5'h01 << i;
      tick(1);
      ev <= 5'h00;
      rchk(ADDR_DEV_STATUS, pexp[i]);
      clr(ADDR_DEV_STATUS);
    end
    pwd(4'h4);
    rchk(ADDR_DEV_STATUS, 8'h05);
    pwd(4'h8);
    rchk(ADDR_DEV_STATUS, 8'h01);
    clr(ADDR_DEV_STATUS);
    cs <= 1'b0;
    pwd(4'h4);
    rchk(ADDR_DEV_STATUS, 8'h04);
    check("fail_output", {7'h00, fail_output}, 8'h00);
    pwd(4'h3);
    rchk(ADDR_DEV_STATUS, 8'h04);
    pwd(4'h2);
    rchk(ADDR_DEV_STATUS, 8'h00);
    c24 <= 1'b1;
    pwd(4'h4);
    pwd(4'h2);
    rchk(ADDR_DEV_STATUS, 8'h04);
    pwd(4'h8);
    rchk(ADDR_DEV_STATUS, 8'h00);
    for (int i = 0; i < 4; i++) begin
      flt <= 4'h1 << i;
      tick(60);
      check("tx_enable", {7'h00, tx_enable}, 8'h00);
      flt <= 4'h0;
      rchk(ADDR_BUS_COMM, fexp[i]);
      clr(ADDR_BUS_COMM);
      rchk(ADDR_BUS_COMM, 8'h00);
      check("tx_enable", {7'h00, tx_enable}, 8'h01);
    end
    cm <= 3'h1;
    flt <= 4'h1;
    tick(20);
    flt <= 4'h0;
    // let the supply level pass the pin synchroniser before the receiver comes back
    tick(4);
    cm <= 3'h3;
    sil <= 1'b1;
    se <= 1'b1;
    tick(10);
    sil <= 1'b0;
    se <= 1'b0;
    rchk(ADDR_BUS_COMM, 8'h00);
    cm <= 3'h7;
    se <= 1'b1;
    tick(2);
    se <= 1'b0;
    rchk(ADDR_BUS_COMM, 8'h08);
    clr(ADDR_BUS_COMM);
    sil <= 1'b1;
    wait_int();
    sil <= 1'b0;
    clr(ADDR_BUS_COMM);
    rchk(ADDR_BUS_COMM, 8'h00);
    mask <= 1'b0;
    sil <= 1'b1;
    tick(10);
    check("int_n", {7'h00, int_n}, 8'h01);
    sil <= 1'b0;
    clr(ADDR_BUS_COMM);
    rchk(ADDR_BUS_COMM, 8'h10);
    oi <= 1'b1;
    tick(1);
    oi <= 1'b0;
    wait_int();
    clr(ADDR_BUS_COMM);
    rchk(ADDR_BUS_COMM, 8'h00);
    conclude();
  end
endmodule // bus_wake_status_bank_tb_top
